// ==== hdl/tsios_sequencer.sv ====
// Target-side phase sequencer for one I/O process at a time.
// Assumes a bus phy that moves one byte per strobe and reports bus events.
`timescale 1ns/1ps
module tsios_sequencer (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // Bus events from the phy
  input  wire logic       sel_i,
  input  wire logic       atn_i,
  input  wire logic       bus_reset_i,
  input  wire logic       unexp_disc_i,
  input  wire logic       byte_done_i,
  input  wire logic [7:0] byte_in_i,
  // Executor interface
  input  wire logic       cdb_done_i,
  input  wire logic       early_status_i,
  input  wire logic       has_data_i,
  input  wire logic       data_done_i,
  input  wire logic       disc_req_i,
  input  wire logic       mid_data_i,
  input  wire logic       retry_req_i,
  input  wire logic       resume_i,
  input  wire logic       done_i,
  input  wire logic [2:0] outcome_i,
  input  wire logic       cond_met_i,
  input  wire logic       link_i,
  input  wire logic       flag_i,
  input  wire logic [31:0] last_lba_i,
  // Bus control toward the phy, then lun, nexus, base LBA and start/end strobes toward the executor
  output logic [2:0]      phase_o,
  output logic            bsy_o,
  output logic            byte_req_o,
  output logic [7:0]      byte_out_o,
  output logic [2:0]      lun_o,
  output logic            nexus_o,
  output logic [31:0]     base_lba_o,
  output logic            cmd_start_o,
  output logic            io_end_o
);

  ////////////////////////////////////////////////////////////////////////
  // Status encoding

  logic [7:0] status_byte;
  // Link bit as latched with the command block, so status and message agree
  logic       linked_q;
  logic       linked_d;

  tsios_status_enc u_enc (
    .outcome_i  (outcome_i),
    .cond_met_i (cond_met_i),
    .linked_i   (linked_q),
    .status_o   (status_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state

  typedef enum {
    S_FREE, S_MSG_OUT, S_COMMAND, S_EXEC, S_DATA_IN, S_STATUS,
    S_MSG_IN, S_SAVE, S_DISC, S_RESTORE, S_WAIT_RES, S_RESEL, S_IDENT
  } tsios_state_t;

  tsios_state_t           state_q, state_d;
  tsios_pkg::tsios_phase_t phase_q, phase_d;
  logic        bsy_q, bsy_d;
  logic        req_q, req_d;
  logic [7:0]  out_q, out_d;
  logic [2:0]  lun_q, lun_d;
  logic        nexus_q, nexus_d;
  logic [31:0] base_q, base_d;
  logic        start_q, start_d;
  logic        end_q, end_d;
  logic        flag_q, flag_d;

  function automatic logic aborted(input logic rst, input logic drop);
    aborted = rst | drop;
  endfunction

  always_comb begin
    state_d  = state_q;
    phase_d  = phase_q;
    bsy_d    = bsy_q;
    req_d    = 1'b0;
    out_d    = out_q;
    lun_d    = lun_q;
    nexus_d  = nexus_q;
    base_d   = base_q;
    start_d  = 1'b0;
    end_d    = 1'b0;
    linked_d = linked_q;
    flag_d   = flag_q;
    if (aborted(bus_reset_i, unexp_disc_i)) begin
      // No status byte on hard reset or unexpected disconnect
      state_d = S_FREE;
      phase_d = tsios_pkg::TSIOS_PH_FREE;
      bsy_d   = 1'b0;
      nexus_d = 1'b0;
      end_d   = nexus_q;
    end else begin
      case (state_q)
        S_FREE: begin
          if (sel_i && atn_i) begin
            state_d = S_MSG_OUT;
            phase_d = tsios_pkg::TSIOS_PH_MSG_OUT;
            bsy_d   = 1'b1;
            req_d   = 1'b1;
          end else if (resume_i && nexus_q) begin
            state_d = S_RESEL;
            phase_d = tsios_pkg::TSIOS_PH_RESELECT;
            bsy_d   = 1'b1;
          end
        end
        S_MSG_OUT: begin
          if (byte_done_i) begin
            if (byte_in_i[7]) begin
              lun_d   = byte_in_i[tsios_pkg::LUN_W-1:0];
              nexus_d = 1'b1;
              state_d = S_COMMAND;
              phase_d = tsios_pkg::TSIOS_PH_COMMAND;
              start_d = 1'b1;
            end else begin
              // Abort-class message: end without status
              state_d = S_FREE;
              phase_d = tsios_pkg::TSIOS_PH_FREE;
              bsy_d   = 1'b0;
              nexus_d = 1'b0;
              end_d   = 1'b1;
            end
          end else begin
            req_d = 1'b1;
          end
        end
        S_COMMAND: begin
          if (early_status_i || cdb_done_i) begin
            state_d  = early_status_i ? S_STATUS : S_EXEC;
            linked_d = link_i;
            flag_d   = flag_i;
          end
        end
        S_EXEC: begin
          if (disc_req_i) begin
            state_d = mid_data_i ? S_SAVE : S_DISC;
            phase_d = tsios_pkg::TSIOS_PH_MSG_IN;
          end else if (retry_req_i) begin
            state_d = S_RESTORE;
            phase_d = tsios_pkg::TSIOS_PH_MSG_IN;
          end else if (done_i) begin
            state_d = S_STATUS;
          end else if (has_data_i) begin
            state_d = S_DATA_IN;
            phase_d = tsios_pkg::TSIOS_PH_DATA_IN;
          end
        end
        S_DATA_IN: begin
          if (data_done_i || disc_req_i || retry_req_i) begin
            state_d = S_EXEC;
          end
        end
        S_SAVE: begin
          out_d = tsios_pkg::MSG_SAVE_PTR;
          req_d = ~byte_done_i;
          if (byte_done_i) begin
            state_d = S_DISC;
          end
        end
        S_DISC: begin
          out_d = tsios_pkg::MSG_DISCONNECT;
          req_d = ~byte_done_i;
          if (byte_done_i) begin
            state_d = S_WAIT_RES;
            phase_d = tsios_pkg::TSIOS_PH_FREE;
            bsy_d   = 1'b0;
          end
        end
        S_RESTORE: begin
          out_d = tsios_pkg::MSG_RESTORE;
          req_d = ~byte_done_i;
          if (byte_done_i) begin
            state_d = S_EXEC;
          end
        end
        S_WAIT_RES: begin
          if (resume_i) begin
            state_d = S_RESEL;
            phase_d = tsios_pkg::TSIOS_PH_RESELECT;
            bsy_d   = 1'b1;
          end
        end
        S_RESEL: begin
          if (sel_i) begin
            state_d = S_IDENT;
            phase_d = tsios_pkg::TSIOS_PH_MSG_IN;
          end
        end
        S_IDENT: begin
          out_d = tsios_pkg::MSG_IDENTIFY | {5'h00, lun_q};
          req_d = ~byte_done_i;
          if (byte_done_i) begin
            state_d = S_EXEC;
          end
        end
        S_STATUS: begin
          phase_d = tsios_pkg::TSIOS_PH_STATUS;
          out_d   = status_byte;
          req_d   = ~byte_done_i;
          if (byte_done_i) begin
            state_d = S_MSG_IN;
            phase_d = tsios_pkg::TSIOS_PH_MSG_IN;
            linked_d = linked_q && (outcome_i == 3'(tsios_pkg::TSIOS_OUT_OK));
          end
        end
        S_MSG_IN: begin
          if (linked_q) begin
            out_d = flag_q ? tsios_pkg::MSG_LINKED_FLG : tsios_pkg::MSG_LINKED;
          end else begin
            out_d = tsios_pkg::MSG_COMPLETE;
          end
          req_d = ~byte_done_i;
          if (byte_done_i) begin
            if (linked_q) begin
              state_d = S_COMMAND;
              phase_d = tsios_pkg::TSIOS_PH_COMMAND;
              base_d  = last_lba_i;
              start_d = 1'b1;
            end else begin
              state_d = S_FREE;
              phase_d = tsios_pkg::TSIOS_PH_FREE;
              bsy_d   = 1'b0;
              nexus_d = 1'b0;
              end_d   = 1'b1;
            end
          end
        end
        default: begin
          state_d = S_FREE;
          phase_d = tsios_pkg::TSIOS_PH_FREE;
          bsy_d   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q  <= S_FREE;
      phase_q  <= tsios_pkg::TSIOS_PH_FREE;
      bsy_q    <= 1'b0;
      req_q    <= 1'b0;
      out_q    <= 8'h00;
      lun_q    <= 3'h0;
      nexus_q  <= 1'b0;
      base_q   <= 32'h0000_0000;
      start_q  <= 1'b0;
      end_q    <= 1'b0;
      linked_q <= 1'b0;
      flag_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      phase_q  <= phase_d;
      bsy_q    <= bsy_d;
      req_q    <= req_d;
      out_q    <= out_d;
      lun_q    <= lun_d;
      nexus_q  <= nexus_d;
      base_q   <= base_d;
      start_q  <= start_d;
      end_q    <= end_d;
      linked_q <= linked_d;
      flag_q   <= flag_d;
    end
  end

  assign phase_o     = phase_q;
  assign bsy_o       = bsy_q;
  assign byte_req_o  = req_q;
  assign byte_out_o  = out_q;
  assign lun_o       = lun_q;
  assign nexus_o     = nexus_q;
  assign base_lba_o  = base_q;
  assign cmd_start_o = start_q;
  assign io_end_o    = end_q;

endmodule

// ==== hdl/tsios_pkg.sv ====
// Constants for the target status and I/O sequencer.
// Assumes one 50 MHz clock and an external bus phy that handles handshakes.
package tsios_pkg;

  // Status byte layout
  localparam int unsigned CODE_LSB = 1;
  localparam int unsigned CODE_MSB = 5;

  // Status byte values
  localparam logic [7:0] ST_GOOD      = 8'h00;
  localparam logic [7:0] ST_CHECK     = 8'h02;
  localparam logic [7:0] ST_COND_MET  = 8'h04;
  localparam logic [7:0] ST_BUSY      = 8'h08;
  localparam logic [7:0] ST_INTERM    = 8'h10;
  localparam logic [7:0] ST_INTERM_CM = 8'h14;
  localparam logic [7:0] ST_RES_CONF  = 8'h18;
  localparam logic [7:0] ST_CMD_TERM  = 8'h22;
  localparam logic [7:0] ST_QUEUE_FUL = 8'h28;

  // Message bytes sent in MESSAGE IN
  localparam logic [7:0] MSG_COMPLETE   = 8'h00;
  localparam logic [7:0] MSG_SAVE_PTR   = 8'h02;
  localparam logic [7:0] MSG_RESTORE    = 8'h03;
  localparam logic [7:0] MSG_DISCONNECT = 8'h04;
  localparam logic [7:0] MSG_LINKED     = 8'h0a;
  localparam logic [7:0] MSG_LINKED_FLG = 8'h0b;
  localparam logic [7:0] MSG_IDENTIFY   = 8'h80;
  localparam int unsigned LUN_W         = 3;

  // Bus phases driven toward the phy
  typedef enum logic [2:0] {
    TSIOS_PH_FREE     = 3'h0,
    TSIOS_PH_MSG_OUT  = 3'h1,
    TSIOS_PH_COMMAND  = 3'h2,
    TSIOS_PH_DATA_IN  = 3'h3,
    TSIOS_PH_DATA_OUT = 3'h4,
    TSIOS_PH_STATUS   = 3'h5,
    TSIOS_PH_MSG_IN   = 3'h6,
    TSIOS_PH_RESELECT = 3'h7
  } tsios_phase_t;

  // Completion outcome reported by the command executor
  typedef enum logic [2:0] {
    TSIOS_OUT_OK    = 3'h0,
    TSIOS_OUT_CHECK = 3'h1,
    TSIOS_OUT_BUSY  = 3'h2,
    TSIOS_OUT_RESV  = 3'h3,
    TSIOS_OUT_TERM  = 3'h4,
    TSIOS_OUT_QFULL = 3'h5,
    TSIOS_OUT_ABORT = 3'h6
  } tsios_outcome_t;

  localparam int unsigned LBA_W = 32;

endpackage

// ==== hdl/tsios_status_enc.sv ====
// Status byte encoder: picks the status code from the completion outcome.
// Assumes the sequencer reloads its output every cycle it spends in the status state.
`timescale 1ns/1ps
module tsios_status_enc (
  input  wire logic [2:0] outcome_i,
  input  wire logic       cond_met_i,
  input  wire logic       linked_i,
  output logic      [7:0] status_o
);

  logic [7:0] code;

  always_comb begin
    unique case (tsios_pkg::tsios_outcome_t'(outcome_i))
      tsios_pkg::TSIOS_OUT_OK: begin
        if (linked_i) begin
          code = cond_met_i ? tsios_pkg::ST_INTERM_CM : tsios_pkg::ST_INTERM;
        end else begin
          code = cond_met_i ? tsios_pkg::ST_COND_MET : tsios_pkg::ST_GOOD;
        end
      end
      tsios_pkg::TSIOS_OUT_CHECK: code = tsios_pkg::ST_CHECK;
      tsios_pkg::TSIOS_OUT_BUSY:  code = tsios_pkg::ST_BUSY;
      tsios_pkg::TSIOS_OUT_RESV:  code = tsios_pkg::ST_RES_CONF;
      tsios_pkg::TSIOS_OUT_TERM:  code = tsios_pkg::ST_CMD_TERM;
      tsios_pkg::TSIOS_OUT_QFULL: code = tsios_pkg::ST_QUEUE_FUL;
      default:                    code = tsios_pkg::ST_CHECK;
    endcase
    // Reserved bits forced low whatever the table holds
    status_o = '0;
    status_o[tsios_pkg::CODE_MSB:tsios_pkg::CODE_LSB] =
      code[tsios_pkg::CODE_MSB:tsios_pkg::CODE_LSB];
  end

endmodule

// ==== testbench/tsios_chk.sv ====
// Port checker for the target sequencer.
// Bound onto tsios_sequencer; sees its ports only.
`timescale 1ns/1ps
module tsios_chk (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       sel_i,
  input wire logic       atn_i,
  input wire logic       bus_reset_i,
  input wire logic       byte_done_i,
  input wire logic [2:0] phase_o,
  input wire logic       bsy_o,
  input wire logic       byte_req_o,
  input wire logic [7:0] byte_out_o,
  input wire logic       cmd_start_o,
  input wire logic       io_end_o
);
  localparam logic [2:0] PF = 3'h0, PO = 3'h1, PC = 3'h2, PS = 3'h5, PM = 3'h6;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Byte accepted by the far side in status or message-in
  sequence s_st; phase_o == PS && byte_req_o && byte_done_i && !bus_reset_i; endsequence
  sequence s_mi; phase_o == PM && byte_req_o && byte_done_i && !bus_reset_i; endsequence
  property p_resv; phase_o == PS && byte_req_o |-> byte_out_o[7:6] == 2'h0 && !byte_out_o[0];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bit set");
  property p_code; phase_o == PS && byte_req_o |->
    byte_out_o inside {8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h22, 8'h28}; endproperty
  a_code: assert property (p_code) else $error("undefined status value");
  property p_sel; phase_o == PF && sel_i && atn_i && !bus_reset_i |=>
    phase_o == PO && bsy_o && byte_req_o; endproperty
  a_sel: assert property (p_sel) else $error("selection not followed by msg out");
  // The message byte is requested one idle cycle after the status byte
  property p_stm; s_st |=> phase_o == PM ##1 phase_o == PM && byte_req_o; endproperty
  a_stm: assert property (p_stm) else $error("status not followed by msg in");
  property p_intm; s_st ##0 byte_out_o inside {8'h10, 8'h14} |=> ##1 byte_out_o[7:1] == 7'h05;
  endproperty
  a_intm: assert property (p_intm) else $error("linked message missing");
  property p_fin; s_st ##0 !(byte_out_o inside {8'h10, 8'h14}) |=> ##1 byte_out_o == 8'h00;
  endproperty
  a_fin: assert property (p_fin) else $error("series not ended");
  property p_end; s_mi ##0 byte_out_o == 8'h00 |=> phase_o == PF && !bsy_o && io_end_o;
  endproperty
  a_end: assert property (p_end) else $error("no bus free after complete");
  property p_link; s_mi ##0 byte_out_o[7:1] == 7'h05 |=> phase_o == PC && cmd_start_o;
  endproperty
  a_link: assert property (p_link) else $error("no next linked command");
  property p_rst; bus_reset_i |=> phase_o == PF && !bsy_o && !byte_req_o; endproperty
  a_rst: assert property (p_rst) else $error("hard reset not honoured");
endmodule
bind tsios_sequencer tsios_chk u_tsios_chk (.clk_sys_i, .reset_n_i, .sel_i, .atn_i,
  .bus_reset_i, .byte_done_i, .phase_o, .bsy_o, .byte_req_o, .byte_out_o, .cmd_start_o,
  .io_end_o);

// ==== testbench/tsios_init_model.sv ====
// Initiator stand-in: answers each byte request, promptly or slowly.
// Drives on the falling edge; keeps saved and active pointer counts.
`timescale 1ns/1ps
module tsios_init_model (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] phase_i,
  input  wire logic       req_i,
  input  wire logic [7:0] byte_i,
  input  wire logic [2:0] lun_i,
  input  wire logic       slow_i,
  output logic            done_o,
  output logic      [7:0] byte_o
);
  logic [2:0] wait_q;
  int         act_ptr;
  int         sav_ptr;
  always @(negedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      byte_o <= 8'h00;
      wait_q <= 3'h0;
      act_ptr <= 0;
      sav_ptr <= 0;
    end else if (done_o) begin
      done_o <= 1'b0;
      byte_o <= ~byte_o;
    end else if (req_i && wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end else if (req_i) begin
      done_o <= 1'b1;
      wait_q <= slow_i ? 3'h4 : 3'h0;
      if (phase_i == 3'h1) byte_o <= 8'h80 | lun_i;
      if (phase_i == 3'h6 && byte_i[7:1] == 7'h05) sav_ptr <= sav_ptr + 1;
      if (phase_i == 3'h6 && byte_i == 8'h02) sav_ptr <= act_ptr;
      if (phase_i == 3'h6 && (byte_i == 8'h03 || byte_i[7])) act_ptr <= sav_ptr;
    end
  end
endmodule

// ==== testbench/tsios_sequencer_bench.sv ====
// Self-checking bench for the target sequencer.
// The initiator model answers bytes; the bench plays the executor.
`timescale 1ns/1ps
module tsios_sequencer_bench;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        sel_i, atn_i, bus_reset_i, unexp_disc_i, byte_done_i, cdb_done_i;
  logic        early_status_i, has_data_i, data_done_i, disc_req_i, mid_data_i;
  logic        retry_req_i, resume_i, done_i, cond_met_i, link_i, flag_i, slow;
  logic        bsy_o, byte_req_o, nexus_o, cmd_start_o, io_end_o, chained;
  logic [2:0]  outcome_i, phase_o, lun_o, lun;
  logic [7:0]  byte_in_i, byte_out_o;
  logic [31:0] last_lba_i, base_lba_o;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          seed = 32'hdf238d84;
  tsios_sequencer u_tsios_sequencer (
    .clk_sys_i, .reset_n_i, .sel_i, .atn_i, .bus_reset_i, .unexp_disc_i, .byte_done_i,
    .byte_in_i, .cdb_done_i, .early_status_i, .has_data_i, .data_done_i, .disc_req_i,
    .mid_data_i, .retry_req_i, .resume_i, .done_i, .outcome_i, .cond_met_i, .link_i,
    .flag_i, .last_lba_i, .phase_o, .bsy_o, .byte_req_o, .byte_out_o, .lun_o, .nexus_o,
    .base_lba_o, .cmd_start_o, .io_end_o);
  tsios_init_model u_tsios_init_model (
    .clk_sys_i, .reset_n_i, .phase_i(phase_o), .req_i(byte_req_o), .byte_i(byte_out_o),
    .lun_i(lun), .slow_i(slow), .done_o(byte_done_i), .byte_o(byte_in_i));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  task test_done;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Wait for cmd_start (0), io_end (1) or a given phase (2)
  task wt(input int k, input logic [2:0] ph);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (!(k == 0 ? cmd_start_o === 1'b1 : k == 1 ? io_end_o === 1'b1 :
                 phase_o === ph) && n < 400);
    if (n >= 400) begin
      error_cnt++;
      $display("ERROR %0t wait timed out", $time);
      test_done();
    end
  endtask
  function automatic logic [7:0] est(input logic [2:0] oc, input logic cm, input logic lk);
    case (oc)
      3'h0: est = lk ? (cm ? 8'h14 : 8'h10) : (cm ? 8'h04 : 8'h00);
      3'h2: est = 8'h08;
      3'h3: est = 8'h18;
      3'h4: est = 8'h22;
      3'h5: est = 8'h28;
      default: est = 8'h02;
    endcase
  endfunction
  // Scoreboard: every byte the initiator accepts in status or msg in
  always @(posedge clk_sys_i) begin
    if (reset_n_i && byte_req_o && byte_done_i && phase_o inside {3'h5, 3'h6}) begin
      chk(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0) chk(byte_out_o, exp_q.pop_front());
    end
  end
  task automatic sel_cmd;
    @(negedge clk_sys_i);
    lun = $random(seed);
    slow = $random(seed);
    sel_i = 1'b1;
    atn_i = 1'b1;
    wt(2, 3'h1);
    sel_i = 1'b0;
    atn_i = 1'b0;
    wt(0, 3'h0);
    chk(lun_o, lun);
  endtask
  task automatic cdb(input logic dat);
    @(negedge clk_sys_i);
    has_data_i = dat;
    last_lba_i = $random(seed);
    cdb_done_i = 1'b1;
    @(negedge clk_sys_i);
    cdb_done_i = 1'b0;
  endtask
  task automatic run(input logic [2:0] oc);
    logic lk;
    logic dat;
    lk = $random(seed);
    dat = $random(seed);
    if (!chained) sel_cmd();
    link_i = lk;
    flag_i = lk & $random(seed);
    cdb(dat);
    if (dat) begin
      wt(2, 3'h3);
      data_done_i = 1'b1;
      @(negedge clk_sys_i);
      data_done_i = 1'b0;
      has_data_i = 1'b0;
    end
    @(negedge clk_sys_i);
    outcome_i = oc;
    cond_met_i = $random(seed);
    done_i = 1'b1;
    chained = lk && oc == 3'h0;
    exp_q.push_back(est(oc, cond_met_i, lk));
    exp_q.push_back(chained ? (flag_i ? 8'h0b : 8'h0a) : 8'h00);
    @(negedge clk_sys_i);
    done_i = 1'b0;
    wt(chained ? 0 : 1, 3'h0);
    if (chained) chk(base_lba_o, last_lba_i);
  endtask
  initial begin
    {sel_i, atn_i, bus_reset_i, unexp_disc_i, cdb_done_i, early_status_i, has_data_i} = '0;
    {data_done_i, disc_req_i, mid_data_i, retry_req_i, resume_i, done_i, cond_met_i} = '0;
    {link_i, flag_i, slow, chained, outcome_i, lun, last_lba_i} = '0;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    // Every outcome twice; a busy command is simply issued again later
    for (int i = 0; i < 16; i++) run(3'(i));
    // Disconnect partway through data, then reselection
    sel_cmd();
    {link_i, flag_i, cond_met_i} = 3'h0;
    mid_data_i = 1'b1;
    cdb(1'b1);
    wt(2, 3'h3);
    disc_req_i = 1'b1;
    exp_q.push_back(8'h02);
    exp_q.push_back(8'h04);
    exp_q.push_back(8'h80 | lun);
    wt(2, 3'h0);
    disc_req_i = 1'b0;
    mid_data_i = 1'b0;
    resume_i = 1'b1;
    @(negedge clk_sys_i);
    resume_i = 1'b0;
    wt(2, 3'h7);
    sel_i = 1'b1;
    wt(2, 3'h3);
    // Repeat the transfer from the saved pointers
    retry_req_i = 1'b1;
    exp_q.push_back(8'h03);
    wt(2, 3'h6);
    retry_req_i = 1'b0;
    wt(2, 3'h3);
    sel_i = 1'b0;
    data_done_i = 1'b1;
    @(negedge clk_sys_i);
    {data_done_i, has_data_i, outcome_i, done_i} = {5'h00, 1'b1};
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    @(negedge clk_sys_i);
    done_i = 1'b0;
    wt(1, 3'h0);
    // Status straight from the command phase
    sel_cmd();
    {link_i, early_status_i} = 2'h1;
    outcome_i = $random(seed);
    cond_met_i = $random(seed);
    exp_q.push_back(est(outcome_i, cond_met_i, 1'b0));
    exp_q.push_back(8'h00);
    @(negedge clk_sys_i);
    early_status_i = 1'b0;
    wt(1, 3'h0);
    // Hard reset aborts a command with no status
    sel_cmd();
    bus_reset_i = 1'b1;
    @(negedge clk_sys_i);
    bus_reset_i = 1'b0;
    chk(phase_o, 3'h0);
    repeat (4) @(negedge clk_sys_i);
    chk(exp_q.size(), 0);
    // Unexpected disconnect ends the process with no status
    sel_cmd();
    unexp_disc_i = 1'b1;
    @(negedge clk_sys_i);
    unexp_disc_i = 1'b0;
    chk(io_end_o, 1'b1);
    chk(nexus_o, 1'b0);
    chk(phase_o, 3'h0);
    repeat (4) @(negedge clk_sys_i);
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule
